// file: src/acm_ctrl.sv
// Converter clock source, divider, core enables, sample control and input mode registers
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "acm_consts.svh"

// Notes on behaviour
// - Top two bits pick clock: 11 FAST_RC_OSCILLATOR-oscillator, 10 reference three, 01 system, 00 bus three.
// - Six-bit divider field sets the control clock division ratio.
// - Shared core enable bit one enables, zero disables its digital logic.
// - Core four enable at bit 20, core three at bit 19.
// - Bits 22 and 21 of control three always read zero.
// - Manual sample bit overrides all; sampling holds until software clears it.
// - Automatic sample time field is ignored while manual sampling is used.
// - Manual sampling with the shared core enabled connects class 2 and 3 inputs only, never class 1.
// - Hardware never clears the manual sample bit.
// - Each input has a differential bit; one differential, zero single-ended.
// - Each input has a signed bit; one signed, zero unsigned result.
module acm_ctrl (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	input  wire logic [10:0]          input_class1_i,
	output var  logic [31:0]          wb_dat_o,
	output var  logic                 wb_ack_o,
	output var  acm_pkg::acm_ctrl_type ctrl_o,
	output var  logic                 ctrl_tick_o,
	output var  logic                 sample_o,
	output var  logic [10:0]          sample_connect_o,
	output var  logic                 convert_o,
	output var  logic [10:0]          input_diff_o,
	output var  logic [10:0]          input_signed_o
);
	acm_pkg::acm_bus_state_type bus_r;
	acm_pkg::acm_bus_state_type bus_nxt;
	logic [31:0] ctrl3_r;
	logic [31:0] ctrl3_nxt;
	logic [31:0] imode_r;
	logic [31:0] imode_nxt;
	logic [31:0] auto_sample_time_r;
	logic [31:0] auto_sample_time_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	logic        req_r;
	logic        req_nxt;
	logic        tick_w;
	logic        sampling_w;
	logic        convert_w;
	logic        tick_r;
	logic        sample_r;
	logic [10:0] connect_r;
	logic [10:0] connect_nxt;
	logic        convert_r;
	logic        wr_stb;
	logic        rd_stb;

	// Byte-lane merge of write data into a register, limited to implemented bits
	function automatic logic [31:0] acm_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] lane;
		lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		acm_merge = ((old_v & ~lane) | (new_v & lane)) & mask;
	endfunction : acm_merge

	// Pick every other bit of the mode register, starting at a given offset
	function automatic logic [10:0] acm_pick(input logic [31:0] v, input int unsigned ofs);
		logic [10:0] r;
		r = 11'h000;
		for (int n = 0; n < `ACM_NUM_INPUTS; n++)
			r[n] = v[2 * n + ofs];
		acm_pick = r;
	endfunction : acm_pick

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && (bus_r == acm_pkg::ACM_IDLE);
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && (bus_r == acm_pkg::ACM_IDLE);

	// Register writes, reads and bus handshake
	always_comb
	begin
		bus_nxt   = acm_pkg::ACM_IDLE;
		ctrl3_nxt = ctrl3_r;
		imode_nxt = imode_r;
		auto_sample_time_nxt  = auto_sample_time_r;
		rdat_nxt  = rdat_r;
		req_nxt   = 1'b0;
		if (wb_cyc_i && wb_stb_i && (bus_r == acm_pkg::ACM_IDLE))
			bus_nxt = acm_pkg::ACM_ACK;
		if (wr_stb)
		begin
			unique case (wb_adr_i)
				`ACM_CTRL3_OFS:
				begin
					// unimplemented masked, sample bit held as written
					ctrl3_nxt = acm_merge(ctrl3_r, wb_dat_i, wb_sel_i, `ACM_CTRL3_MASK);
					// request acted on as a pulse
					req_nxt = wb_sel_i[0] && wb_dat_i[`ACM_REQUEST_BIT];
					ctrl3_nxt[`ACM_REQUEST_BIT] = 1'b0;
				end
				`ACM_IMODE1_OFS:
					imode_nxt = acm_merge(imode_r, wb_dat_i, wb_sel_i, `ACM_IMODE_MASK);
				`ACM_SAMPTIME_OFS:
					auto_sample_time_nxt = acm_merge(auto_sample_time_r, wb_dat_i, wb_sel_i, `ACM_AUTO_SAMPLE_TIME_MASK);
				default:
				begin
				end
			endcase
		end
		if (rd_stb)
		begin
			unique case (wb_adr_i)
				`ACM_CTRL3_OFS:    rdat_nxt = ctrl3_r;
				`ACM_IMODE1_OFS:   rdat_nxt = imode_r;
				`ACM_SAMPTIME_OFS: rdat_nxt = auto_sample_time_r;
				`ACM_STATUS_OFS:   rdat_nxt = {30'h0000_0000, convert_r, sampling_w};
				default:           rdat_nxt = `ACM_ZERO32;
			endcase
		end
	end

	// Register bus and control state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bus_r   <= acm_pkg::ACM_IDLE;
			ctrl3_r <= `ACM_ZERO32;
			imode_r <= `ACM_ZERO32;
			auto_sample_time_r  <= `ACM_ZERO32;
			rdat_r  <= `ACM_ZERO32;
			req_r   <= 1'b0;
		end
		else
		begin
			bus_r   <= bus_nxt;
			ctrl3_r <= ctrl3_nxt;
			imode_r <= imode_nxt;
			auto_sample_time_r  <= auto_sample_time_nxt;
			rdat_r  <= rdat_nxt;
			req_r   <= req_nxt;
		end
	end

	acm_clk_div u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.div_i  (ctrl3_r[`ACM_DIV_HI:`ACM_DIV_LO]),
		.tick_o (tick_w)
	);

	// sample sequencing, sample time ignored under manual control
	acm_sampler u_manual_sample_hold (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.tick_i     (tick_w),
		.manual_i   (ctrl3_r[`ACM_SAMPLE_BIT]),
		.start_i    (req_r),
		.auto_sample_time_i     (auto_sample_time_r[`ACM_AUTO_SAMPLE_TIME_HI:`ACM_AUTO_SAMPLE_TIME_LO]),
		.sampling_o (sampling_w),
		.convert_o  (convert_w)
	);

	// manual sampling with the shared core enabled reaches class 2 and 3 inputs only
	always_comb
	begin
		connect_nxt = 11'h000;
		if (ctrl3_r[`ACM_SAMPLE_BIT] && ctrl3_r[`ACM_SHARED_EN_BIT])
			connect_nxt = ~input_class1_i;
	end

	// Output registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tick_r    <= 1'b0;
			sample_r  <= 1'b0;
			connect_r <= 11'h000;
			convert_r <= 1'b0;
		end
		else
		begin
			tick_r    <= tick_w;
			sample_r  <= sampling_w;
			connect_r <= connect_nxt;
			convert_r <= convert_w && ctrl3_r[`ACM_SHARED_EN_BIT];
		end
	end

	assign wb_dat_o         = rdat_r;
	assign wb_ack_o         = (bus_r == acm_pkg::ACM_ACK);
	assign ctrl_o.clk_src   = ctrl3_r[`ACM_SEL_HI:`ACM_SEL_LO];
	assign ctrl_o.ctrl_div  = ctrl3_r[`ACM_DIV_HI:`ACM_DIV_LO];
	assign ctrl_o.shared_en = ctrl3_r[`ACM_SHARED_EN_BIT];
	assign ctrl_o.core4_en  = ctrl3_r[`ACM_CORE4_EN_BIT];
	assign ctrl_o.core3_en  = ctrl3_r[`ACM_CORE3_EN_BIT];
	assign ctrl_tick_o      = tick_r;
	assign sample_o         = sample_r;
	assign sample_connect_o = connect_r;
	assign convert_o        = convert_r;
	assign input_diff_o     = acm_pick(imode_r, 1);
	assign input_signed_o   = acm_pick(imode_r, 0);
endmodule : acm_ctrl
`default_nettype wire

// file: src/acm_consts.svh
// Offsets, field positions and reset values for the converter clock and mode control block
`ifndef ACM_CONSTS_SVH
`define ACM_CONSTS_SVH

// Register byte offsets
`define ACM_CTRL3_OFS        4'h0
`define ACM_IMODE1_OFS       4'h4
`define ACM_SAMPTIME_OFS     4'h8
`define ACM_STATUS_OFS       4'hC

// Control register three fields
`define ACM_SEL_HI           31
`define ACM_SEL_LO           30
`define ACM_DIV_HI           29
`define ACM_DIV_LO           24
`define ACM_SHARED_EN_BIT    23
`define ACM_CORE4_EN_BIT     20
`define ACM_CORE3_EN_BIT     19
`define ACM_SAMPLE_BIT       1
`define ACM_REQUEST_BIT      0
// Writable bits; 22 and 21 and all others read as zero
`define ACM_CTRL3_MASK       32'hFF98_0003

// Automatic sample time field in the second control word
`define ACM_AUTO_SAMPLE_TIME_HI          25
`define ACM_AUTO_SAMPLE_TIME_LO          16
`define ACM_AUTO_SAMPLE_TIME_MASK        32'h03FF_0000

// Input mode register: inputs 0 to 10, bits 21:0 implemented
`define ACM_IMODE_MASK       32'h003F_FFFF
`define ACM_NUM_INPUTS       11

// Clock source codes
`define ACM_SRC_PERIPHERAL_BUS_CLOCK_THREE       2'h0
`define ACM_SRC_SYSCLK       2'h1
`define ACM_SRC_REFERENCE_CLOCK_THREE      2'h2
`define ACM_SRC_FRC          2'h3

// Reset values and counter increments
`define ACM_ZERO32           32'h0000_0000
`define ACM_ZERO6            6'h00
`define ACM_ONE6             6'h01
`define ACM_ZERO10           10'h000
`define ACM_ONE10            10'h001

`endif

// file: src/acm_pkg.sv
// Types for the converter clock and mode control block
package acm_pkg;

	// Decoded controls presented to the analog cores
	typedef struct packed {
		logic [1:0]  clk_src;
		logic [5:0]  ctrl_div;
		logic        shared_en;
		logic        core4_en;
		logic        core3_en;
	} acm_ctrl_type;

	// Bus state machine
	typedef enum logic [1:0] {
		ACM_IDLE = 2'b01,
		ACM_ACK  = 2'b10
	} acm_bus_state_type;

	// Sample state for the shared core
	typedef enum logic [2:0] {
		ACM_S_HOLD   = 3'b001,
		ACM_S_MANUAL = 3'b010,
		ACM_S_AUTO   = 3'b100
	} acm_manual_sample_hold_state_type;

endpackage : acm_pkg

// file: src/acm_clk_div.sv
// Control clock divider: produces a one-cycle control clock tick from the converter clock
`timescale 1ns/100ps
`default_nettype none
`include "acm_consts.svh"

module acm_clk_div (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [5:0] div_i,
	output var  logic       tick_o
);
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic       tick_r;
	logic       tick_nxt;

	// Count up to divide ratio; zero treated as one
	always_comb
	begin
		tick_nxt = 1'b0;
		cnt_nxt  = cnt_r + `ACM_ONE6;
		if ((cnt_r + `ACM_ONE6) >= div_i)
		begin
			cnt_nxt  = `ACM_ZERO6;
			tick_nxt = 1'b1;
		end
	end

	// Register counter and tick
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r  <= `ACM_ZERO6;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;
endmodule : acm_clk_div
`default_nettype wire

// file: src/acm_sampler.sv
// Shared core sample and hold sequencer: manual hold, automatic timing and conversion start
`timescale 1ns/100ps
`default_nettype none
`include "acm_consts.svh"

module acm_sampler (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       tick_i,
	input  wire logic       manual_i,
	input  wire logic       start_i,
	input  wire logic [9:0] auto_sample_time_i,
	output var  logic       sampling_o,
	output var  logic       convert_o
);
	acm_pkg::acm_manual_sample_hold_state_type st_r;
	acm_pkg::acm_manual_sample_hold_state_type st_nxt;
	logic [9:0] cnt_r;
	logic [9:0] cnt_nxt;
	logic       conv_r;
	logic       conv_nxt;

	// Manual sample wins over everything; otherwise a request runs an automatic sample
	always_comb
	begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		conv_nxt = 1'b0;
		unique case (st_r)
			acm_pkg::ACM_S_HOLD:
			begin
				if (manual_i)
					st_nxt = acm_pkg::ACM_S_MANUAL;
				else if (start_i)
				begin
					st_nxt  = acm_pkg::ACM_S_AUTO;
					cnt_nxt = `ACM_ZERO10;
				end
			end
			acm_pkg::ACM_S_MANUAL:
			begin
				// Sample time field ignored; hold ends only when software clears
				if (!manual_i && start_i)
					conv_nxt = 1'b1;
				if (!manual_i)
					st_nxt = acm_pkg::ACM_S_HOLD;
			end
			acm_pkg::ACM_S_AUTO:
			begin
				if (manual_i)
					st_nxt = acm_pkg::ACM_S_MANUAL;
				else if (tick_i)
				begin
					cnt_nxt = cnt_r + `ACM_ONE10;
					if ((cnt_r + `ACM_ONE10) >= auto_sample_time_i)
					begin
						st_nxt   = acm_pkg::ACM_S_HOLD;
						conv_nxt = 1'b1;
					end
				end
			end
			default:
				st_nxt = acm_pkg::ACM_S_HOLD;
		endcase
	end

	// Register sample state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r   <= acm_pkg::ACM_S_HOLD;
			cnt_r  <= `ACM_ZERO10;
			conv_r <= 1'b0;
		end
		else
		begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			conv_r <= conv_nxt;
		end
	end

	assign sampling_o = (st_r != acm_pkg::ACM_S_HOLD);
	assign convert_o  = conv_r;
endmodule : acm_sampler
`default_nettype wire

// file: tb/acm_core_model.sv
// Behavioural model of the analog cores behind the control block
`timescale 1ns/100ps
`default_nettype none
module acm_core_model #(
	parameter logic [10:0] CLASS1 = 11'h00F
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  var  acm_pkg::acm_ctrl_type ctrl_i,
	input  wire logic                  convert_i,
	output var  logic [10:0]           class1_o,
	output var  int                    conv_count_o
);
	// Fixed class 1 wiring of the inputs
	assign class1_o = CLASS1;
	// Shared core counts conversion starts it sees
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			conv_count_o <= 0;
		else if (convert_i)
			conv_count_o <= conv_count_o + 1;
	end
endmodule : acm_core_model
`default_nettype wire

// file: tb/acm_ctrl_props.sv
// Port checker for the converter clock and mode control block
`timescale 1ns/100ps
`default_nettype none
module acm_ctrl_props (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [3:0]            wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [10:0]           input_class1_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire acm_pkg::acm_ctrl_type ctrl_o,
	input wire logic                  sample_o,
	input wire logic [10:0]           sample_connect_o,
	input wire logic                  convert_o,
	input wire logic [10:0]           input_diff_o,
	input wire logic [10:0]           input_signed_o
);
	logic wr0;
	logic wr4;
	// Completed writes to control register three and the input mode register
	assign wr0 = wb_ack_o && wb_we_i && wb_adr_i == 4'h0;
	assign wr4 = wb_ack_o && wb_we_i && wb_adr_i == 4'h4;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o) |=> wb_ack_o)
		else $error("ack not one cycle after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_RSV_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[22:21] == 2'h0)
		else $error("unimplemented bits read nonzero");
	AST_CLK_SRC: assert property (wr0 && wb_sel_i[3] |=> ctrl_o.clk_src == $past(wb_dat_i[31:30]))
		else $error("clock source not from write");
	AST_DIV: assert property (wr0 && wb_sel_i[3] |=> ctrl_o.ctrl_div == $past(wb_dat_i[29:24]))
		else $error("divider not from write");
	AST_ENABLES: assert property (wr0 && wb_sel_i[2] |=> {ctrl_o.shared_en, ctrl_o.core4_en, ctrl_o.core3_en}
		== {$past(wb_dat_i[23]), $past(wb_dat_i[20]), $past(wb_dat_i[19])})
		else $error("core enables not from write");
	AST_MODE_BITS: assert property (wr4 && wb_sel_i[1] |=> input_diff_o[5] == $past(wb_dat_i[11])
		&& input_signed_o[5] == $past(wb_dat_i[10]))
		else $error("input five mode bits misplaced");
	AST_HOLD: assert property (wr0 && wb_sel_i[0] && wb_dat_i[1] |=> ##1 sample_o [*3])
		else $error("manual sample not held");
	AST_CONNECT: assert property ((sample_connect_o & input_class1_i) == 11'h000)
		else $error("class 1 input connected");
	AST_CONV_PULSE: assert property (convert_o |=> !convert_o)
		else $error("convert longer than one cycle");
	// Main scenarios reached
	cover property (wr0 && wb_dat_i[1]);
	cover property (convert_o);
	cover property (wr4);
endmodule : acm_ctrl_props
bind acm_ctrl acm_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.input_class1_i(input_class1_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctrl_o(ctrl_o),
	.sample_o(sample_o), .sample_connect_o(sample_connect_o), .convert_o(convert_o),
	.input_diff_o(input_diff_o), .input_signed_o(input_signed_o));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the converter clock and mode control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [10:0] CLS = 11'h00F;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [3:0] sel = 4'hF;
	logic [3:0] lanes = 4'hF;
	logic [31:0] q;
	logic [31:0] dat_o;
	logic ack, tick, manual_sample_hold, conv;
	logic [10:0] conn, diff, sgn, cls;
	acm_pkg::acm_ctrl_type ctrl;
	int num_errors = 0;
	int n_compared = 0;
	int cyc_n = 0;
	int conv_n, n;
	// Clock of 50 ns period
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	acm_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .input_class1_i(cls), .wb_dat_o(dat_o), .wb_ack_o(ack), .ctrl_o(ctrl),
		.ctrl_tick_o(tick), .sample_o(manual_sample_hold), .sample_connect_o(conn), .convert_o(conv),
		.input_diff_o(diff), .input_signed_o(sgn));
	acm_core_model #(.CLASS1(CLS)) u_cores (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl), .convert_i(conv),
		.class1_o(cls), .conv_count_o(conv_n));
	task summarize;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask : chk
	// One classic Wishbone cycle, held until ack is sampled
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= lanes;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, e, q);
	endtask : rd
	// Wait at most lim cycles for a signal to go high
	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim)
		begin
			@(negedge clk_i);
			n++;
		end
	endtask : wait_hi
	// Hang guard
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 3000)
		begin
			num_errors++;
			summarize();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(4'h0, 32'h0000_0000, "ctrl3 reset");
		rd(4'h4, 32'h0000_0000, "imode reset");
		rd(4'hE, 32'h0000_0000, "unmapped read");
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b1, 4'h0, {s[1:0], 30'h0000_0000});
			@(negedge clk_i);
			chk("clk_src", s, 32'(ctrl.clk_src));
		end
		bus(1'b1, 4'h0, 32'h0398_0000);
		@(negedge clk_i);
		chk("enables", 32'h7, {ctrl.shared_en, ctrl.core4_en, ctrl.core3_en});
		wait_hi(tick, 100);
		@(negedge clk_i);
		wait_hi(tick, 100);
		chk("tick gap", 32'd3, n + 1);
		bus(1'b1, 4'h8, 32'h0001_0000);
		bus(1'b1, 4'h0, 32'hFFFF_FFFE);
		rd(4'h0, 32'hFF98_0002, "ctrl3 ones");
		repeat (40) @(negedge clk_i);
		chk("held sample", 32'h1, manual_sample_hold);
		chk("no convert held", 32'd0, conv_n);
		chk("connect", {21'h00_0000, ~CLS}, conn);
		rd(4'hC, 32'h0000_0001, "status sampling");
		// Triggers stay clear, hold released before the request
		bus(1'b1, 4'h0, 32'h0380_0000);
		bus(1'b1, 4'h0, 32'h0380_0001);
		wait_hi(conv, 60);
		chk("convert", 32'h1, conv);
		// Clearing the hold and requesting in one write starts a conversion
		bus(1'b1, 4'h0, 32'h0380_0002);
		bus(1'b1, 4'h0, 32'h0380_0001);
		wait_hi(conv, 60);
		chk("hold release convert", 32'h1, conv);
		bus(1'b1, 4'h0, 32'h0300_0001);
		repeat (60) @(negedge clk_i);
		chk("gated convert", 32'd2, conv_n);
		bus(1'b1, 4'h4, 32'h0015_5555);
		@(negedge clk_i);
		chk("signed bits", 32'h7FF, {diff, sgn});
		bus(1'b1, 4'h4, 32'hFFFF_FFFF);
		@(negedge clk_i);
		chk("diff bits", 32'h3F_FFFF, {diff, sgn});
		rd(4'h4, 32'h003F_FFFF, "imode ones");
		// Only the lowest byte lane is written
		lanes = 4'h1;
		bus(1'b1, 4'h4, 32'h0000_0000);
		lanes = 4'hF;
		rd(4'h4, 32'h003F_FF00, "imode low lane");
		summarize();
	end
endmodule : testbench
`default_nettype wire
